/* File: src/cbc_defines.svh */
// Timing counts, state-count targets and reset values for the coprocessor bus-cycle logic.
`ifndef CBC_DEFINES_SVH
`define CBC_DEFINES_SVH

`define CBC_DATA_W          16
`define CBC_CLK_NS          100
`define CBC_CLK2_NS         50
`define CBC_ERR_GAP_CLK2    6
`define CBC_ERR_GAP_CLK     ((`CBC_ERR_GAP_CLK2 * `CBC_CLK2_NS + `CBC_CLK_NS - 1) / `CBC_CLK_NS)
`define CBC_GAP_W           3
`define CBC_TRS_FAST_WRITE  2'h1
`define CBC_TRS_SLOW        2'h2
`define CBC_WAIT_W          4
`define CBC_RST_DATA        16'h0000
`define CBC_RST_INACTIVE_N  1'h1

`endif

/* File: src/cbc_pkg.sv */
// State types of the coprocessor bus-cycle link, one for each end.
package cbc_pkg;
    typedef enum logic [1:0] {
        CBC_IDLE,
        CBC_TRS,
        CBC_TP
    } cbc_bus_state_t;

    typedef enum logic [1:0] {
        CBC_H_IDLE,
        CBC_H_ADDR,
        CBC_H_WAIT
    } cbc_host_state_t;
endpackage

/* File: src/cbc_link_if.sv */
// Bus wires between the host CPU end and the coprocessor end.
`timescale 1ns/1ps
`include "cbc_defines.svh"
interface cbc_link_if;
    logic                   addr_strobe_n;
    logic                   cyc_write;
    logic                   cyc_io;
    logic                   cyc_sel;
    logic                   cyc_cmd;
    logic [`CBC_DATA_W-1:0] host_data;
    logic                   host_data_oe;
    logic                   host_ready_n;
    logic                   ready_pass;
    logic                   cop_ready_out_n;
    logic [`CBC_DATA_W-1:0] cop_data;
    logic                   cop_data_oe;
    logic                   busy_n;
    logic                   operand_xfer_request;
    logic                   error_n;
    logic [`CBC_DATA_W-1:0] data_lines;
    logic                   ready_n;

    // The shared data bus: whoever enables drives, otherwise it floats high.
    assign data_lines = cop_data_oe ? cop_data : (host_data_oe ? host_data : {`CBC_DATA_W{1'h1}});
    // Wired-OR of active-low readies; the coprocessor's one is only passed when no extra waits are wanted.
    assign ready_n = host_ready_n & (cop_ready_out_n | ~ready_pass);

    modport cop (
        input  addr_strobe_n, cyc_write, cyc_io, cyc_sel, cyc_cmd, data_lines, ready_n,
        output cop_ready_out_n, cop_data, cop_data_oe, busy_n, operand_xfer_request, error_n
    );
    modport host (
        input  cop_ready_out_n, data_lines, ready_n, busy_n, operand_xfer_request, error_n,
        output addr_strobe_n, cyc_write, cyc_io, cyc_sel, cyc_cmd, host_data, host_data_oe,
        host_ready_n, ready_pass
    );
endinterface

/* File: src/cbc_host.sv */
// Host CPU end: issues bus cycles, adds optional wait states and terminates them with ready.
`timescale 1ns/1ps
`include "cbc_defines.svh"
module cbc_host (
    input  wire logic                   i_clk,
    input  wire logic                   i_rstn,
    cbc_link_if.host                    link,
    input  wire logic                   i_req,
    input  wire logic                   i_write,
    input  wire logic                   i_io,
    input  wire logic                   i_sel,
    input  wire logic                   i_cmd,
    input  wire logic [`CBC_DATA_W-1:0] i_wdata,
    input  wire logic [`CBC_WAIT_W-1:0] i_extra_waits,
    input  wire logic                   i_pipeline,
    output logic                        o_req_taken,
    output logic                        o_done,
    output logic [`CBC_DATA_W-1:0]      o_rdata
);
    // ==========================================================
    // State and next values
    // ==========================================================
    cbc_pkg::cbc_host_state_t state, next_state;
    logic                   ads_n, next_ads_n;
    logic                   cw, next_cw;
    logic                   cio, next_cio;
    logic                   csel, next_csel;
    logic                   ccmd, next_ccmd;
    logic [`CBC_WAIT_W-1:0] cwaits, next_cwaits;
    logic [`CBC_DATA_W-1:0] wd, next_wd;
    logic [`CBC_DATA_W-1:0] pend_wd, next_pend_wd;
    logic                   dwrite, next_dwrite;
    logic                   doe, next_doe;
    logic                   dsel, next_dsel;
    logic [`CBC_WAIT_W-1:0] dwaits, next_dwaits;
    logic                   hrdy_n, next_hrdy_n;
    logic                   pass, next_pass;
    logic                   armed, next_armed;
    logic [`CBC_WAIT_W-1:0] wcnt, next_wcnt;
    logic                   taken, next_taken;
    logic                   done, next_done;
    logic [`CBC_DATA_W-1:0] rdata, next_rdata;
    logic [`CBC_WAIT_W-1:0] eff;
    logic                   trig;

    always_comb begin
        next_state   = state;
        next_ads_n   = 1'h1;
        next_cw      = cw;
        next_cio     = cio;
        next_csel    = csel;
        next_ccmd    = ccmd;
        next_cwaits  = cwaits;
        next_pend_wd = pend_wd;
        next_wd      = wd;
        next_dwrite  = dwrite;
        next_doe     = doe;
        next_dsel    = dsel;
        next_dwaits  = dwaits;
        next_hrdy_n  = 1'h1;
        next_pass    = pass;
        next_armed   = armed;
        next_wcnt    = wcnt;
        next_taken   = 1'h0;
        next_done    = 1'h0;
        next_rdata   = rdata;
        eff          = (dwaits == '0) ? `CBC_WAIT_W'(1) : dwaits;
        trig         = armed || !dsel || !link.cop_ready_out_n;
        case (state)
            cbc_pkg::CBC_H_IDLE: begin
                if (i_req) begin
                    next_ads_n   = 1'h0;
                    next_cw      = i_write;
                    next_cio     = i_io;
                    next_csel    = i_sel;
                    next_ccmd    = i_cmd;
                    next_cwaits  = i_extra_waits;
                    next_pend_wd = i_wdata;
                    next_taken   = 1'h1;
                    next_state   = cbc_pkg::CBC_H_ADDR;
                end
            end
            cbc_pkg::CBC_H_ADDR: begin
                // Data and cycle kind of the running cycle are held apart from the strobed fields,
                // so a pipelined strobe cannot disturb data still being transferred.
                next_wd     = pend_wd;
                next_dwrite = cw;
                next_doe    = cw;
                next_dsel   = csel && cio;
                next_dwaits = cwaits;
                next_pass   = csel && cio && (cwaits == '0);
                next_armed  = 1'h0;
                next_wcnt   = '0;
                next_state  = cbc_pkg::CBC_H_WAIT;
            end
            cbc_pkg::CBC_H_WAIT: begin
                if (!link.ready_n) begin
                    next_done  = 1'h1;
                    next_doe   = 1'h0;
                    next_pass  = 1'h0;
                    if (!dwrite) begin
                        next_rdata = link.data_lines;
                    end
                    if (!ads_n) begin
                        next_state = cbc_pkg::CBC_H_ADDR;
                    end else if (i_req) begin
                        next_ads_n   = 1'h0;
                        next_cw      = i_write;
                        next_cio     = i_io;
                        next_csel    = i_sel;
                        next_ccmd    = i_cmd;
                        next_cwaits  = i_extra_waits;
                        next_pend_wd = i_wdata;
                        next_taken   = 1'h1;
                        next_state   = cbc_pkg::CBC_H_ADDR;
                    end else begin
                        next_state = cbc_pkg::CBC_H_IDLE;
                    end
                end else if (!pass && hrdy_n && trig) begin
                    next_armed = 1'h1;
                    next_wcnt  = wcnt + `CBC_WAIT_W'(1);
                    if (wcnt + `CBC_WAIT_W'(1) == eff) begin
                        next_hrdy_n = 1'h0;
                        if (i_req && i_pipeline) begin
                            next_ads_n   = 1'h0;
                            next_cw      = i_write;
                            next_cio     = i_io;
                            next_csel    = i_sel;
                            next_ccmd    = i_cmd;
                            next_cwaits  = i_extra_waits;
                            next_pend_wd = i_wdata;
                            next_taken   = 1'h1;
                        end
                    end
                end
            end
            default: next_state = cbc_pkg::CBC_H_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state   <= cbc_pkg::CBC_H_IDLE;
            ads_n   <= `CBC_RST_INACTIVE_N;
            cw      <= 1'h0;
            cio     <= 1'h0;
            csel    <= 1'h0;
            ccmd    <= 1'h0;
            cwaits  <= '0;
            pend_wd <= `CBC_RST_DATA;
            wd      <= `CBC_RST_DATA;
            dwrite  <= 1'h0;
            doe     <= 1'h0;
            dsel    <= 1'h0;
            dwaits  <= '0;
            hrdy_n  <= `CBC_RST_INACTIVE_N;
            pass    <= 1'h0;
            armed   <= 1'h0;
            wcnt    <= '0;
            taken   <= 1'h0;
            done    <= 1'h0;
            rdata   <= `CBC_RST_DATA;
        end else begin
            state   <= next_state;
            ads_n   <= next_ads_n;
            cw      <= next_cw;
            cio     <= next_cio;
            csel    <= next_csel;
            ccmd    <= next_ccmd;
            cwaits  <= next_cwaits;
            pend_wd <= next_pend_wd;
            wd      <= next_wd;
            dwrite  <= next_dwrite;
            doe     <= next_doe;
            dsel    <= next_dsel;
            dwaits  <= next_dwaits;
            hrdy_n  <= next_hrdy_n;
            pass    <= next_pass;
            armed   <= next_armed;
            wcnt    <= next_wcnt;
            taken   <= next_taken;
            done    <= next_done;
            rdata   <= next_rdata;
        end
    end

    assign link.addr_strobe_n = ads_n;
    assign link.cyc_write     = cw;
    assign link.cyc_io        = cio;
    assign link.cyc_sel       = csel;
    assign link.cyc_cmd       = ccmd;
    assign link.host_data     = wd;
    assign link.host_data_oe  = doe;
    assign link.host_ready_n  = hrdy_n;
    assign link.ready_pass    = pass;
    assign o_req_taken        = taken;
    assign o_done             = done;
    assign o_rdata            = rdata;
endmodule

/* File: src/cbc_cop.sv */
// Coprocessor end: bus-cycle state machine, read drive and ready timing, busy/request/fault ordering.
`timescale 1ns/1ps
`include "cbc_defines.svh"
module cbc_cop (
    input  wire logic                   i_clk,
    input  wire logic                   i_rstn,
    cbc_link_if.cop                     link,
    input  wire logic [`CBC_DATA_W-1:0] i_rd_data,
    input  wire logic                   i_slow_write,
    input  wire logic                   i_exec_start,
    input  wire logic                   i_exec_done,
    input  wire logic                   i_need_operand,
    input  wire logic                   i_fault,
    output logic [`CBC_DATA_W-1:0]      o_wr_data,
    output logic                        o_wr_cmd,
    output logic                        o_wr_strobe,
    output logic                        o_rd_done,
    output logic                        o_busy
);
    // ==========================================================
    // Bus-cycle state machine
    // ==========================================================
    cbc_pkg::cbc_bus_state_t state, next_state;
    logic                   cw, next_cw;
    logic                   csel, next_csel;
    logic                   ccmd, next_ccmd;
    logic                   cslow, next_cslow;
    logic [1:0]             trs, next_trs;
    logic                   rdy_n, next_rdy_n;
    logic                   doe, next_doe;
    logic [`CBC_DATA_W-1:0] dout, next_dout;
    logic [`CBC_DATA_W-1:0] wdata, next_wdata;
    logic                   wcmd, next_wcmd;
    logic                   wstb, next_wstb;
    logic                   rdone, next_rdone;
    logic                   strobe_now;
    logic                   end_now;

    // One decode for when a cycle's ready falls due.
    function automatic logic [1:0] ready_slot(input logic wr, input logic slow);
        ready_slot = (wr && !slow) ? `CBC_TRS_FAST_WRITE : `CBC_TRS_SLOW;
    endfunction

    always_comb begin
        next_state = state;
        next_cw    = cw;
        next_csel  = csel;
        next_ccmd  = ccmd;
        next_cslow = cslow;
        next_trs   = trs;
        next_dout  = dout;
        next_wdata = wdata;
        next_wcmd  = wcmd;
        next_wstb  = 1'h0;
        next_rdone = 1'h0;
        strobe_now = !link.addr_strobe_n;
        end_now    = (state == cbc_pkg::CBC_TRS) && !link.ready_n;
        if ((state == cbc_pkg::CBC_IDLE && strobe_now) || (end_now && strobe_now)) begin
            next_cw    = link.cyc_write;
            next_csel  = link.cyc_sel && link.cyc_io;
            next_ccmd  = link.cyc_cmd;
            next_cslow = i_slow_write;
            next_dout  = i_rd_data;
        end
        if (end_now && csel) begin
            next_wstb  = cw;
            next_rdone = !cw;
            if (cw) begin
                next_wdata = link.data_lines;
                next_wcmd  = ccmd;
            end
        end
        case (state)
            cbc_pkg::CBC_IDLE: begin
                if (strobe_now) begin
                    next_state = cbc_pkg::CBC_TRS;
                    next_trs   = 2'h1;
                end
            end
            cbc_pkg::CBC_TRS: begin
                if (!link.ready_n) begin
                    if (strobe_now) begin
                        next_state = cbc_pkg::CBC_TP;
                    end else begin
                        next_state = cbc_pkg::CBC_IDLE;
                    end
                end else if (trs != 2'h3) begin
                    next_trs = trs + 2'h1;
                end
            end
            cbc_pkg::CBC_TP: begin
                next_state = cbc_pkg::CBC_TRS;
                next_trs   = 2'h1;
            end
            default: next_state = cbc_pkg::CBC_IDLE;
        endcase
        next_rdy_n = !((next_state == cbc_pkg::CBC_TRS) && next_csel && (next_trs == ready_slot(next_cw, next_cslow)));
        next_doe   = (next_state == cbc_pkg::CBC_TRS) && next_csel && !next_cw;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= cbc_pkg::CBC_IDLE;
            cw    <= 1'h0;
            csel  <= 1'h0;
            ccmd  <= 1'h0;
            cslow <= 1'h0;
            trs   <= 2'h0;
            rdy_n <= `CBC_RST_INACTIVE_N;
            doe   <= 1'h0;
            dout  <= `CBC_RST_DATA;
            wdata <= `CBC_RST_DATA;
            wcmd  <= 1'h0;
            wstb  <= 1'h0;
            rdone <= 1'h0;
        end else begin
            state <= next_state;
            cw    <= next_cw;
            csel  <= next_csel;
            ccmd  <= next_ccmd;
            cslow <= next_cslow;
            trs   <= next_trs;
            rdy_n <= next_rdy_n;
            doe   <= next_doe;
            dout  <= next_dout;
            wdata <= next_wdata;
            wcmd  <= next_wcmd;
            wstb  <= next_wstb;
            rdone <= next_rdone;
        end
    end

    // ==========================================================
    // Execution busy, operand request and numeric fault
    // ==========================================================
    logic                  busy, next_busy;
    logic                  busy_n, next_busy_n;
    logic                  err_n, next_err_n;
    logic                  dpend, next_dpend;
    logic                  preq, next_preq;
    logic                  err, next_err;
    logic [`CBC_GAP_W-1:0] since_req, next_since_req;
    logic [`CBC_GAP_W-1:0] since_err, next_since_err;

    always_comb begin
        next_busy      = busy;
        next_dpend     = dpend;
        // Counters saturate, so a fault with no prior request is allowed at once.
        next_since_req = preq ? '0 : ((since_req == `CBC_GAP_W'(`CBC_ERR_GAP_CLK)) ? since_req
                                      : since_req + `CBC_GAP_W'(1));
        next_since_err = err ? '0 : ((since_err == `CBC_GAP_W'(`CBC_ERR_GAP_CLK)) ? since_err
                                     : since_err + `CBC_GAP_W'(1));
        if (!busy && i_exec_start) begin
            next_busy  = 1'h1;
            next_dpend = 1'h0;
        end
        if (busy && i_exec_done) begin
            next_dpend = 1'h1;
        end
        next_preq = busy && !dpend && i_need_operand && !err;
        next_err  = busy && !dpend && !preq && i_fault
                    && (err || since_req >= `CBC_GAP_W'(`CBC_ERR_GAP_CLK));
        if (busy && dpend && !err && since_err >= `CBC_GAP_W'(`CBC_ERR_GAP_CLK)) begin
            next_busy  = 1'h0;
            next_dpend = 1'h0;
        end
        // The active-low pins get flops of their own so no inverter sits after the state.
        next_busy_n = !next_busy;
        next_err_n  = !next_err;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy      <= 1'h0;
            dpend     <= 1'h0;
            preq      <= 1'h0;
            err       <= 1'h0;
            since_req <= `CBC_GAP_W'(`CBC_ERR_GAP_CLK);
            since_err <= `CBC_GAP_W'(`CBC_ERR_GAP_CLK);
            busy_n    <= `CBC_RST_INACTIVE_N;
            err_n     <= `CBC_RST_INACTIVE_N;
        end else begin
            busy      <= next_busy;
            dpend     <= next_dpend;
            preq      <= next_preq;
            err       <= next_err;
            since_req <= next_since_req;
            since_err <= next_since_err;
            busy_n    <= next_busy_n;
            err_n     <= next_err_n;
        end
    end

    assign link.cop_ready_out_n      = rdy_n;
    assign link.cop_data             = dout;
    assign link.cop_data_oe          = doe;
    assign link.busy_n               = busy_n;
    assign link.operand_xfer_request = preq;
    assign link.error_n              = err_n;
    assign o_wr_data                 = wdata;
    assign o_wr_cmd                  = wcmd;
    assign o_wr_strobe               = wstb;
    assign o_rd_done                 = rdone;
    assign o_busy                    = busy;
endmodule

/* File: dv/cbc_link_properties.sv */
// Concurrent checks on the wires joining the host end and the coprocessor end.
`timescale 1ns/1ps
module cbc_link_properties (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic addr_strobe_n,
    input  wire logic cyc_write,
    input  wire logic cyc_io,
    input  wire logic cyc_sel,
    input  wire logic ready_n,
    input  wire logic cop_ready_out_n,
    input  wire logic cop_data_oe,
    input  wire logic busy_n,
    input  wire logic operand_xfer_request,
    input  wire logic error_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // ==========================================
    // Gap counters
    // Both start saturated so a fault with no earlier request is not flagged.
    logic [2:0] req_gap;
    logic [2:0] err_gap;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            req_gap <= 3'h7;
            err_gap <= 3'h7;
        end else begin
            req_gap <= operand_xfer_request ? 3'h0 : ((req_gap == 3'h7) ? req_gap : req_gap + 3'h1);
            err_gap <= !error_n ? 3'h0 : ((err_gap == 3'h7) ? err_gap : err_gap + 3'h1);
        end
    end

    // ==========================================
    // Cycle starts
    sequence s_sel_strobe;
        !addr_strobe_n && cyc_io && cyc_sel;
    endsequence
    sequence s_read;
        s_sel_strobe ##0 (ready_n && !cyc_write);
    endsequence
    sequence s_write;
        s_sel_strobe ##0 (ready_n && cyc_write);
    endsequence
    sequence s_pipe_read;
        s_sel_strobe ##0 (!ready_n && !cyc_write);
    endsequence

    // ==========================================
    // Properties
    a_read_drive_early: assert property (s_read |=> cop_data_oe [*2])
        else $error("read data not driven from second clock");
    a_read_ready_late: assert property (s_read |=> cop_ready_out_n ##1 !cop_ready_out_n)
        else $error("read ready not in third clock");
    a_write_ready_time: assert property (s_write |=> ##[0:1] !cop_ready_out_n)
        else $error("write ready missing");
    a_pipe_read_ready: assert property (s_pipe_read |=> cop_ready_out_n ##[1:2] !cop_ready_out_n)
        else $error("pipelined read ready misplaced");
    a_ready_single_pulse: assert property (!cop_ready_out_n |=> cop_ready_out_n)
        else $error("ready longer than one clock");
    a_ready_sel_only: assert property (!cop_ready_out_n |-> cyc_io && cyc_sel)
        else $error("ready for unselected cycle");
    a_drive_while_wait: assert property (cop_data_oe && ready_n && addr_strobe_n |=> cop_data_oe)
        else $error("data released while waiting");
    a_float_on_idle: assert property (cop_data_oe && !ready_n && addr_strobe_n |=> !cop_data_oe)
        else $error("data not floated on idle");
    a_request_in_busy: assert property (operand_xfer_request |-> !busy_n)
        else $error("operand request outside busy");
    a_fault_after_req: assert property ($fell(error_n) |-> req_gap >= 3'h3)
        else $error("fault too soon after request");
    a_fault_before_idle: assert property ($rose(busy_n) |-> err_gap >= 3'h3)
        else $error("busy ended too soon after fault");
endmodule

/* File: dv/tb_top.sv */
// Bench joining both ends: bus cycles from the host user side and an execution sequence.
`timescale 1ns/1ps
`include "cbc_defines.svh"
module tb_top;
    logic        i_clk;
    logic        i_rstn;
    logic        req, wr, io, sel, slow, pipe, x_start, x_done, x_need, x_fault;
    logic [3:0]  waits;
    logic [15:0] dat;
    logic        o_req_taken, o_done, o_wr_cmd, o_wr_strobe, o_rd_done, o_busy;
    logic [15:0] o_rdata, o_wr_data;
    logic [15:0] got_q[$];
    logic [16:0] exp_q[$];
    int          at_q[$], t_q[$];
    int          cyc, n_rd, n_wr, n_mismatch, tests_run, l_rd, l_fw, l_sw, l_wt, l_x, k;

    cbc_link_if cbc_link_if_i ();
    cbc_host cbc_host_i (.i_clk(i_clk), .i_rstn(i_rstn), .link(cbc_link_if_i.host), .i_req(req), .i_write(wr),
        .i_io(io), .i_sel(sel), .i_cmd(dat[0]), .i_wdata(dat), .i_extra_waits(waits), .i_pipeline(pipe),
        .o_req_taken(o_req_taken), .o_done(o_done), .o_rdata(o_rdata));
    cbc_cop cbc_cop_i (.i_clk(i_clk), .i_rstn(i_rstn), .link(cbc_link_if_i.cop), .i_rd_data(dat),
        .i_slow_write(slow), .i_exec_start(x_start), .i_exec_done(x_done), .i_need_operand(x_need),
        .i_fault(x_fault), .o_wr_data(o_wr_data), .o_wr_cmd(o_wr_cmd), .o_wr_strobe(o_wr_strobe),
        .o_rd_done(o_rd_done), .o_busy(o_busy));
    cbc_link_properties cbc_link_properties_i (.i_clk(i_clk), .i_rstn(i_rstn),
        .addr_strobe_n(cbc_link_if_i.addr_strobe_n), .cyc_write(cbc_link_if_i.cyc_write),
        .cyc_io(cbc_link_if_i.cyc_io), .cyc_sel(cbc_link_if_i.cyc_sel), .ready_n(cbc_link_if_i.ready_n),
        .cop_ready_out_n(cbc_link_if_i.cop_ready_out_n), .cop_data_oe(cbc_link_if_i.cop_data_oe),
        .busy_n(cbc_link_if_i.busy_n), .operand_xfer_request(cbc_link_if_i.operand_xfer_request),
        .error_n(cbc_link_if_i.error_n));

    always #50 i_clk = ~i_clk;

    // ==========================================
    // Completion monitor and hang guard
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_done === 1'h1) got_q.push_back(o_rdata);
        if (o_done === 1'h1) at_q.push_back(cyc);
        if (o_rd_done === 1'h1) n_rd++;
        if (o_wr_strobe === 1'h1) n_wr++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s saw %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // The request is held one edge past the take so the coprocessor samples this cycle's read data.
    task automatic start(input logic w, i, s, sl, p, keep, input logic [15:0] d, input logic [3:0] n);
        int j;
        @(negedge i_clk);
        {wr, io, sel, slow, pipe, waits, dat} = {w, i, s, sl, p, n, d};
        req = 1'h1;
        for (j = 0; j < 20 && o_req_taken !== 1'h1; j++) begin
            @(posedge i_clk);
            #1;
        end
        check(16'(j < 20), 16'h1, "request not taken");
        t_q.push_back(cyc);
        exp_q.push_back({~w, (i && s) ? d : 16'hFFFF});
        @(posedge i_clk);
        if (!keep) begin
            @(negedge i_clk);
            req = 1'h0;
        end
    endtask

    task automatic finish(output int len);
        int j;
        logic [16:0] e;
        for (j = 0; j < 40 && got_q.size() == 0; j++) @(negedge i_clk);
        check(16'(j < 40), 16'h1, "cycle not ended");
        @(negedge i_clk);
        e = exp_q.pop_front();
        len = at_q.pop_front() - t_q.pop_front();
        if (e[16]) check(got_q[0], e[15:0], "read data");
        void'(got_q.pop_front());
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        {i_clk, i_rstn, req, wr, io, sel, slow, pipe, x_start, x_done, x_need, x_fault} = '0;
        {waits, dat, cyc, n_rd, n_wr, n_mismatch, tests_run} = '0;
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_rstn = 1'h1;
        check({cbc_link_if_i.cop_ready_out_n, cbc_link_if_i.cop_data_oe, o_busy}, 16'h4, "reset");
        start(1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 16'hA5C3, 4'h0);
        finish(l_rd);
        check(16'(l_rd), 16'h3, "read length minimum");
        start(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 16'h3C5B, 4'h0);
        finish(l_fw);
        check(16'(l_fw), 16'h2, "fast write length");
        check(o_wr_data, 16'h3C5B, "write data");
        check(16'(o_wr_cmd), 16'h1, "write command flag");
        start(1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 16'h5AA4, 4'h0);
        finish(l_sw);
        check(o_wr_data, 16'h5AA4, "slow write data");
        check(16'(o_wr_cmd), 16'h0, "slow write command flag");
        check(16'(l_sw), 16'(l_fw + 1), "slow write length");
        check(16'(l_rd), 16'(l_sw), "read length");
        // Unselected I/O and a memory cycle: the host must end both itself.
        for (k = 0; k < 2; k++) begin
            start(1'h0, k[0], ~k[0], 1'h0, 1'h0, 1'h0, 16'h0F0F, 4'h1);
            finish(l_x);
        end
        start(1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 16'h7E81, 4'h2);
        finish(l_wt);
        check(16'(l_wt), 16'(l_rd + 2), "extra wait length");
        // Three back-to-back reads, only the first pipelined into its successor (the third request clears pipe).
        start(1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 16'hC001, 4'h1);
        start(1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 16'hC002, 4'h1);
        start(1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 16'hC003, 4'h1);
        for (k = 0; k < 3; k++) finish(l_x);
        check(16'(n_rd), 16'h5, "read strobes");
        check(16'(n_wr), 16'h2, "write strobes");
        @(negedge i_clk);
        {x_start, x_need} = 2'h3;
        @(negedge i_clk);
        x_start = 1'h0;
        for (k = 0; k < 20 && cbc_link_if_i.operand_xfer_request !== 1'h1; k++) @(negedge i_clk);
        check({o_busy, cbc_link_if_i.busy_n}, 16'h2, "busy with request");
        {x_need, x_fault} = 2'h1;
        for (k = 0; k < 20 && cbc_link_if_i.error_n !== 1'h0; k++) @(negedge i_clk);
        check(16'(cbc_link_if_i.error_n), 16'h0, "fault raised");
        {x_done, x_fault} = 2'h2;
        for (k = 0; k < 20 && cbc_link_if_i.busy_n !== 1'h1; k++) @(negedge i_clk);
        check({o_busy, cbc_link_if_i.error_n}, 16'h1, "busy ended after fault");
        x_done = 1'h0;
        conclude();
    end
endmodule
